// >>> keywin_pkg.sv
// Constants for the cipher key and data window register bank.
package keywin_pkg;
   localparam int DATA_W = 32;
   localparam int KEY_W = 256;
   localparam int KEY_WORDS = 8;
   localparam int ADDR_W = 16;
   // Area decode on address bits 15..11.
   localparam int AREA_HI = 15;
   localparam int AREA_LO = 11;
   localparam logic [4:0] AREA_REGS = 5'h00;
   localparam logic [4:0] AREA_PLAIN = 5'h01;
   localparam logic [4:0] AREA_CIPHER = 5'h02;
   // RAM word address bits 10..2.
   localparam int RAM_AW = 9;
   localparam int RAM_LO = 2;
   // Byte offsets of the key words inside the register area.
   localparam logic [10:0] ENC_KEY_BASE = 11'h020;
   localparam logic [10:0] DEC_KEY_BASE = 11'h040;
   // Key setting takes this many clocks after the load strobe.
   localparam int KEY_SET_CYCLES = 14;
   localparam int RAM_DEPTH = 512;
endpackage

// >>> cipher_key_and_data_window_regs.sv
// Key registers and RAM data windows of the user-clock register file.
//
// Function
// - Encrypt key eight words, readable and writable.
// - Decrypt key eight words, readable and writable.
// - Writing decrypt word 0 pulses load strobe.
// - Plain window reads/writes plain RAM port.
// - Cipher window reads/writes cipher RAM port.
// - Writing encrypt word 0 pulses load strobe.
// - Key setting busy 14 cycles after strobe.
// - Address bits 15..11 select area.
// - Read data valid two cycles after request.
`timescale 1ns/100ps
`default_nettype none
module cipher_key_and_data_window_regs
   import keywin_pkg::*;
#(
   parameter int KEY_CYCLES = KEY_SET_CYCLES
)(
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic rst_b,
   // Register interface.
   input wire logic [ADDR_W-1:0] user_side_register_address,
   input wire logic reg_wr_en,
   input wire logic [3:0] reg_wr_byte_en,
   input wire logic [DATA_W-1:0] reg_wr_data,
   input wire logic reg_rd_req,
   output logic reg_rd_valid,
   output logic [DATA_W-1:0] reg_rd_data,
   // Cipher core key side.
   output logic [KEY_W-1:0] encrypt_key_vector,
   output logic encrypt_key_load_strobe,
   output logic encrypt_key_busy,
   output logic [KEY_W-1:0] decrypt_key_vector,
   output logic decrypt_key_load_strobe,
   output logic decrypt_key_busy
);

   // Elaboration check: the busy counter is only eight bits wide.
   if (KEY_CYCLES < 1 || KEY_CYCLES > 255)
   begin : g_bad_key_cycles
      $error("KEY_CYCLES out of range");
   end

   typedef enum logic [1:0] {KS_IDLE = 2'b01, KS_BUSY = 2'b10} kstate_t;

   // Area select from the upper address bits.
   function automatic logic is_area(input logic [ADDR_W-1:0] a,
                                    input logic [4:0] area);
      is_area = (a[AREA_HI:AREA_LO] == area);
   endfunction

   // Key block match on address bits 10..5 inside the register area.
   function automatic logic key_hit(input logic [ADDR_W-1:0] a,
                                    input logic [10:0] base);
      key_hit = is_area(a, AREA_REGS) && (a[10:5] == base[10:5]);
   endfunction

   wire logic [RAM_AW-1:0] ram_addr = user_side_register_address[10:RAM_LO];
   wire logic [2:0] kidx = user_side_register_address[4:2];
   wire logic enc_hit = key_hit(user_side_register_address, ENC_KEY_BASE);
   wire logic dec_hit = key_hit(user_side_register_address, DEC_KEY_BASE);

   // Buffer RAMs with byte write enables; no reset on storage.
   logic [DATA_W-1:0] plain_buffer_ram [RAM_DEPTH];
   logic [DATA_W-1:0] cipher_buffer_ram [RAM_DEPTH];
   logic [DATA_W-1:0] plain_ram_second_port_read;
   logic [DATA_W-1:0] cipher_ram_second_port_read;

   always_ff @(posedge clk_sys)
   begin
      for (int b = 0; b < 4; b++)
      begin
         if (reg_wr_en && reg_wr_byte_en[b] &&
             is_area(user_side_register_address, AREA_PLAIN))
            plain_buffer_ram[ram_addr][8*b +: 8] <= reg_wr_data[8*b +: 8];
         if (reg_wr_en && reg_wr_byte_en[b] &&
             is_area(user_side_register_address, AREA_CIPHER))
            cipher_buffer_ram[ram_addr][8*b +: 8] <= reg_wr_data[8*b +: 8];
      end
      plain_ram_second_port_read <= plain_buffer_ram[ram_addr];
      cipher_ram_second_port_read <= cipher_buffer_ram[ram_addr];
   end

   // Key storage next values; byte enables honoured per word.
   logic [KEY_W-1:0] enc_key_d, enc_key_q, dec_key_d, dec_key_q;
   logic enc_ld_d, enc_ld_q, dec_ld_d, dec_ld_q;

   always_comb
   begin
      enc_key_d = enc_key_q;
      dec_key_d = dec_key_q;
      for (int b = 0; b < 4; b++)
      begin
         if (reg_wr_en && enc_hit && reg_wr_byte_en[b])
            enc_key_d[32*kidx + 8*b +: 8] = reg_wr_data[8*b +: 8];
         if (reg_wr_en && dec_hit && reg_wr_byte_en[b])
            dec_key_d[32*kidx + 8*b +: 8] = reg_wr_data[8*b +: 8];
      end
      // Only word 0 launches key setting, so it must be written last.
      enc_ld_d = reg_wr_en && enc_hit && (kidx == 3'h0);
      dec_ld_d = reg_wr_en && dec_hit && (kidx == 3'h0);
   end

   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         enc_key_q <= '0;
         dec_key_q <= '0;
         enc_ld_q <= 1'b0;
         dec_ld_q <= 1'b0;
      end
      else
      begin
         enc_key_q <= enc_key_d;
         dec_key_q <= dec_key_d;
         enc_ld_q <= enc_ld_d;
         dec_ld_q <= dec_ld_d;
      end
   end

   // Key setting trackers, one per core, counting down from the strobe.
   kstate_t ks_q [2], ks_d [2];
   logic [7:0] kcnt_q [2], kcnt_d [2];
   wire logic [1:0] ld_q = {dec_ld_q, enc_ld_q};

   for (genvar k = 0; k < 2; k++)
   begin : g_ks
      always_comb
      begin
         ks_d[k] = ks_q[k];
         kcnt_d[k] = kcnt_q[k];
         case (ks_q[k])
            KS_IDLE:
            begin
               if (ld_q[k])
               begin
                  ks_d[k] = KS_BUSY;
                  kcnt_d[k] = 8'(KEY_CYCLES - 1);
               end
            end
            KS_BUSY:
            begin
               if (ld_q[k])
                  kcnt_d[k] = 8'(KEY_CYCLES - 1);
               else if (kcnt_q[k] == 8'h00)
                  ks_d[k] = KS_IDLE;
               else
                  kcnt_d[k] = kcnt_q[k] - 8'h01;
            end
            default:
            begin
               ks_d[k] = KS_IDLE;
               kcnt_d[k] = 8'h00;
            end
         endcase
      end

      always_ff @(posedge clk_sys or negedge rst_b)
      begin
         if (!rst_b)
         begin
            ks_q[k] <= KS_IDLE;
            kcnt_q[k] <= 8'h00;
         end
         else
         begin
            ks_q[k] <= ks_d[k];
            kcnt_q[k] <= kcnt_d[k];
         end
      end
   end

   // Read path: request stage, then area mux; valid lands two clocks later.
   logic rd_req_d, rd_req_q, rd_vld_d, rd_vld_q;
   logic [ADDR_W-1:0] rd_addr_d, rd_addr_q;
   logic [DATA_W-1:0] rd_data_d, rd_data_q;

   always_comb
   begin
      rd_req_d = reg_rd_req;
      rd_addr_d = reg_rd_req ? user_side_register_address : rd_addr_q;
      rd_vld_d = rd_req_q;
      rd_data_d = rd_data_q;
      if (rd_req_q)
      begin
         if (is_area(rd_addr_q, AREA_PLAIN))
            rd_data_d = plain_ram_second_port_read;
         else if (is_area(rd_addr_q, AREA_CIPHER))
            rd_data_d = cipher_ram_second_port_read;
         else if (key_hit(rd_addr_q, ENC_KEY_BASE))
            rd_data_d = enc_key_q[32*rd_addr_q[4:2] +: 32];
         else if (key_hit(rd_addr_q, DEC_KEY_BASE))
            rd_data_d = dec_key_q[32*rd_addr_q[4:2] +: 32];
         else
            rd_data_d = '0; // Unmapped words read zero.
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         rd_req_q <= 1'b0;
         rd_vld_q <= 1'b0;
         rd_addr_q <= '0;
         rd_data_q <= '0;
      end
      else
      begin
         rd_req_q <= rd_req_d;
         rd_vld_q <= rd_vld_d;
         rd_addr_q <= rd_addr_d;
         rd_data_q <= rd_data_d;
      end
   end

   // Outputs straight from flip-flops.
   assign reg_rd_valid = rd_vld_q;
   assign reg_rd_data = rd_data_q;
   assign encrypt_key_vector = enc_key_q;
   assign decrypt_key_vector = dec_key_q;
   assign encrypt_key_load_strobe = enc_ld_q;
   assign decrypt_key_load_strobe = dec_ld_q;
   // Bit 1 of the one-hot state is the busy code, so no gate follows it.
   assign encrypt_key_busy = ks_q[0][1];
   assign decrypt_key_busy = ks_q[1][1];

   // Strobe, key storage, read timing and key setting length checks.
   AST_ENC_STROBE: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      reg_wr_en && enc_hit && kidx == 3'h0 |=> encrypt_key_load_strobe)
      else $error("Encrypt strobe missing.");
   AST_DEC_STROBE: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      reg_wr_en && dec_hit && kidx == 3'h0 |=> decrypt_key_load_strobe)
      else $error("Decrypt strobe missing.");
   AST_NO_STROBE: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      !(reg_wr_en && (enc_hit || dec_hit) && kidx == 3'h0)
      |=> !encrypt_key_load_strobe && !decrypt_key_load_strobe)
      else $error("Stray key strobe.");
   AST_ENC_WORD: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      reg_wr_en && enc_hit && kidx == 3'h3 && reg_wr_byte_en == 4'hF
      |=> encrypt_key_vector[127:96] == $past(reg_wr_data))
      else $error("Encrypt word 3 not stored.");
   AST_DEC_WORD: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      reg_wr_en && dec_hit && kidx == 3'h7 && reg_wr_byte_en == 4'hF
      |=> decrypt_key_vector[255:224] == $past(reg_wr_data))
      else $error("Decrypt word 7 not stored.");
   AST_RD_LAT: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      reg_rd_req |-> ##2 reg_rd_valid)
      else $error("Read valid not two cycles later.");
   AST_RD_ONLY: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      reg_rd_valid |-> $past(reg_rd_req, 2))
      else $error("Spurious read valid.");
   AST_KEY_BUSY: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      encrypt_key_load_strobe && KEY_CYCLES == 14
      |=> encrypt_key_busy [*8] ##1 encrypt_key_busy [*6])
      else $error("Encrypt key busy too short.");
   AST_KEY_END: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      $fell(encrypt_key_busy) && KEY_CYCLES == 14
      |-> $past(encrypt_key_load_strobe, 15))
      else $error("Encrypt key busy ends off time.");
   AST_DEC_BUSY: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      decrypt_key_load_strobe && KEY_CYCLES == 14
      |=> decrypt_key_busy [*8] ##1 decrypt_key_busy [*6])
      else $error("Decrypt key busy too short.");
   AST_DEC_END: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      $fell(decrypt_key_busy) && KEY_CYCLES == 14
      |-> $past(decrypt_key_load_strobe, 15))
      else $error("Decrypt key busy ends off time.");
   AST_PLAIN_RD: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      reg_rd_req && is_area(user_side_register_address, AREA_PLAIN)
      && !reg_wr_en
      |=> ##1 reg_rd_data == $past(plain_ram_second_port_read))
      else $error("Plain window read wrong.");
   AST_CIPH_RD: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      reg_rd_req && is_area(user_side_register_address, AREA_CIPHER)
      && !reg_wr_en
      |=> ##1 reg_rd_data == $past(cipher_ram_second_port_read))
      else $error("Cipher window read wrong.");

endmodule
`default_nettype wire

// >>> reg_host_model.sv
// Register bus master model standing in for the processor-side bridge.
`timescale 1ns/100ps
`default_nettype none
module reg_host_model
   import keywin_pkg::*;
(
   // Clock.
   input wire logic clk_sys,
   // Register bus requests.
   output logic [ADDR_W-1:0] addr,
   output logic wr_en,
   output logic [3:0] be,
   output logic [DATA_W-1:0] wdata,
   output logic rd_req
);
   // Idle bus at time zero.
   initial
   begin
      addr = 16'h0000;
      wr_en = 1'b0;
      be = 4'hf;
      wdata = 32'h0000_0000;
      rd_req = 1'b0;
   end
   // One-cycle write; address and data are scrambled once taken.
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
      input logic [3:0] b = 4'hf);
      @(posedge clk_sys);
      addr <= a;
      wdata <= d;
      be <= b;
      wr_en <= 1'b1;
      @(posedge clk_sys);
      wr_en <= 1'b0;
      addr <= ~a;
      wdata <= ~d;
   endtask
   // One-cycle read request; the answer is watched by the caller.
   task automatic rd(input logic [ADDR_W-1:0] a);
      @(posedge clk_sys);
      addr <= a;
      rd_req <= 1'b1;
      @(posedge clk_sys);
      rd_req <= 1'b0;
      addr <= ~a;
   endtask
endmodule
`default_nettype wire

// >>> cipher_key_and_data_window_regs_tb_top.sv
// Self-checking bench for the key registers and RAM data windows.
`timescale 1ns/100ps
`default_nettype none
module cipher_key_and_data_window_regs_tb_top
   import keywin_pkg::*;
;
   logic clk_sys = 1'b0;
   logic rst_b = 1'b0;
   logic [ADDR_W-1:0] addr;
   logic wr_en, rd_req, rd_valid, es, eb, ds, db;
   logic [3:0] be;
   logic [DATA_W-1:0] wdata, rdata;
   logic [KEY_W-1:0] ek, dk, ek_m, dk_m;
   logic [DATA_W-1:0] ram_m [6];
   logic [ADDR_W-1:0] ram_a [6];
   int num_errors = 0;
   int check_count = 0;
   int seed = 32'h0000_1b72;
   // Free-running system clock.
   always #5 clk_sys = ~clk_sys;
   reg_host_model host (.clk_sys(clk_sys), .addr(addr), .wr_en(wr_en),
      .be(be), .wdata(wdata), .rd_req(rd_req));
   cipher_key_and_data_window_regs DUT (.clk_sys(clk_sys), .rst_b(rst_b),
      .user_side_register_address(addr), .reg_wr_en(wr_en),
      .reg_wr_byte_en(be), .reg_wr_data(wdata), .reg_rd_req(rd_req),
      .reg_rd_valid(rd_valid), .reg_rd_data(rdata),
      .encrypt_key_vector(ek), .encrypt_key_load_strobe(es),
      .encrypt_key_busy(eb), .decrypt_key_vector(dk),
      .decrypt_key_load_strobe(ds), .decrypt_key_busy(db));
   // Compare and count; a mismatch is reported at once.
   task automatic chk(input logic [DATA_W-1:0] got,
      input logic [DATA_W-1:0] e);
      check_count++;
      if (got !== e)
      begin
         num_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, e);
      end
   endtask
   // Expected word after a byte-enabled write over a known word.
   function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old,
      input logic [DATA_W-1:0] d, input logic [3:0] b);
      merge = old;
      for (int i = 0; i < 4; i++)
         if (b[i])
            merge[8*i +: 8] = d[8*i +: 8];
   endfunction
   // Verdict and end of run.
   task automatic summarize();
      if (num_errors == 0 && check_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // Read with a bounded wait; the cycle count of the answer is checked.
   task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
      int n;
      host.rd(a);
      for (n = 1; n < 8; n++)
      begin
         @(posedge clk_sys);
         #1;
         if (rd_valid === 1'b1)
            break;
      end
      chk(32'(n), 32'h0000_0001);
      chk(rdata, e);
      if (n == 8)
         summarize();
   endtask
   // Word 0 write: strobe next cycle, then busy for the key setting time.
   task automatic keyload(input bit dec, input logic [DATA_W-1:0] d);
      int n;
      host.wr({5'h00, dec ? DEC_KEY_BASE : ENC_KEY_BASE}, d);
      #1;
      chk({31'h0, dec ? ds : es}, 32'h0000_0001);
      n = 0;
      repeat (20)
      begin
         @(posedge clk_sys);
         #1;
         if ((dec ? db : eb) === 1'b1)
            n++;
      end
      chk(32'(n), 32'(KEY_SET_CYCLES));
   endtask
   // Main sequence: keys high word first, then RAM windows, then holes.
   initial
   begin
      logic [DATA_W-1:0] w;
      int k;
      ek_m = '0;
      dk_m = '0;
      repeat (12) @(posedge clk_sys);
      rst_b <= 1'b1;
      for (k = 7; k >= 0; k--)
      begin
         w = $random(seed);
         ek_m[32*k +: 32] = w;
         if (k == 0)
            keyload(1'b0, w);
         else
            host.wr({5'h00, ENC_KEY_BASE + 11'(4*k)}, w);
         #1;
         chk({30'h0, es, ds}, 32'h0000_0000);
         w = $random(seed);
         dk_m[32*k +: 32] = w;
         if (k == 0)
            keyload(1'b1, w);
         else
            host.wr({5'h00, DEC_KEY_BASE + 11'(4*k)}, w);
         #1;
         chk({30'h0, es, ds}, 32'h0000_0000);
      end
      for (k = 0; k < 8; k++)
      begin
         chk(ek[32*k +: 32], ek_m[32*k +: 32]);
         chk(dk[32*k +: 32], dk_m[32*k +: 32]);
         rd({5'h00, ENC_KEY_BASE + 11'(4*k)}, ek_m[32*k +: 32]);
         rd({5'h00, DEC_KEY_BASE + 11'(4*k)}, dk_m[32*k +: 32]);
      end
      // First, last and a random word of each RAM window.
      for (k = 0; k < 6; k++)
      begin
         w = $random(seed);
         ram_a[k] = {k < 3 ? AREA_PLAIN : AREA_CIPHER,
            k % 3 == 0 ? 9'h000 : k % 3 == 1 ? 9'h1ff : {1'b0, w[7:1], 1'b1},
            2'b00};
         ram_m[k] = $random(seed);
         host.wr(ram_a[k], ram_m[k]);
         // A random byte-enabled write on top exercises a random set of lanes.
         w = $random(seed);
         host.wr(ram_a[k], ~w, w[3:0]);
         ram_m[k] = merge(ram_m[k], ~w, w[3:0]);
      end
      for (k = 0; k < 6; k++)
         rd(ram_a[k], ram_m[k]);
      host.wr(16'h1800, 32'hffff_ffff);
      rd(16'h1800, 32'h0000_0000);
      rd(16'h0000, 32'h0000_0000);
      summarize();
   end
   // Watchdog against a hung run.
   initial
   begin
      #300000;
      num_errors++;
      summarize();
   end
endmodule
`default_nettype wire
